// ==== hw/stag_pkg.sv ====
// constants, register map and types of the sound tone amplitude generator
package stag_pkg;
   localparam int STAG_ADDR_W = 5;
   localparam int STAG_DATA_W = 8;
   // register byte offsets
   localparam logic [4:0] STAG_GENERATOR_CONTROL = 5'h00;
   localparam logic [4:0] STAG_ENVELOPE_CONTROL = 5'h01;
   localparam logic [4:0] STAG_CLOCK_DIVIDER_HIGH = 5'h02;
   localparam logic [4:0] STAG_CLOCK_DIVIDER_LOW = 5'h03;
   localparam logic [4:0] STAG_TONE_HALF_PERIOD_HIGH = 5'h04;
   localparam logic [4:0] STAG_TONE_HALF_PERIOD_LOW = 5'h05;
   localparam logic [4:0] STAG_AMPLITUDE_DUTY_HIGH = 5'h06;
   localparam logic [4:0] STAG_AMPLITUDE_DUTY_LOW = 5'h07;
   localparam logic [4:0] STAG_AMPLITUDE_STEP_HIGH = 5'h08;
   localparam logic [4:0] STAG_AMPLITUDE_STEP_LOW = 5'h09;
   localparam logic [4:0] STAG_AMPLITUDE_LIMIT_HIGH = 5'h0a;
   localparam logic [4:0] STAG_AMPLITUDE_LIMIT_LOW = 5'h0b;
   localparam logic [4:0] STAG_TONE_CYCLES_PER_DURATION = 5'h0c;
   localparam logic [4:0] STAG_NEXT_DATA_FLAG_REG = 5'h0e;
   localparam logic [4:0] STAG_WORKING_AMPLITUDE_HIGH = 5'h10;
   localparam logic [4:0] STAG_WORKING_AMPLITUDE_LOW = 5'h11;
   localparam logic [4:0] STAG_DURATION_COUNT = 5'h12;
   // field positions
   localparam int STAG_GENERATOR_ENABLE_BIT = 7;
   localparam int STAG_TONE_ONLY_BIT = 2;
   localparam int STAG_CONFIG_READY_BIT = 1;
   localparam int STAG_STOP_BIT = 0;
   localparam int STAG_ENVELOPE_ENABLE_BIT = 7;
   localparam int STAG_SHAPE_LSB = 1;
   localparam int STAG_ENVELOPE_DIRECTION_BIT = 0;
   localparam int STAG_NEXT_DATA_FLAG_BIT = 0;
   // reset values and the amplitude maximum
   localparam logic [7:0] STAG_CONTROL_RESET = 8'h00;
   localparam logic [10:0] STAG_VALUE_RESET = 11'h000;
   localparam logic [10:0] STAG_AMP_MAX = 11'h7ff;
   // shape shifts for the non-linear envelopes
   localparam int STAG_GONG_SHIFT = 1;
   localparam int STAG_EXP_SHIFT = 3;

   typedef enum logic [1:0] {
      STAG_SHAPE_LINEAR = 2'b00,
      STAG_SHAPE_GONG = 2'b01,
      STAG_SHAPE_EXP = 2'b10,
      STAG_SHAPE_RSVD = 2'b11
   } stag_shape_type;

   typedef enum logic [1:0] {
      STAG_ST_IDLE = 2'b01,
      STAG_ST_RUN = 2'b10
   } stag_state_type;

   typedef struct packed {
      logic [STAG_ADDR_W-1:0] addr;
      logic [STAG_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } stag_bus_req_type;

   typedef struct packed {
      logic [10:0] divider;
      logic [9:0] tone;
      logic [10:0] amp;
      logic [10:0] step;
      logic [10:0] limit;
      logic [7:0] duration_bits;
   } stag_config_type;
endpackage

// ==== hw/stag_top.sv ====
// register file and core of the sound tone amplitude generator
`timescale 1ns/100ps

// Functional notes
// - envelope stepping happens only while envelope_enable (control bit 7) is set.
// - shape select 00 linear, 01 gong, 10 exponential, 11 reserved (holds).
// - direction 0 raises amplitude (attack), 1 lowers it (decay).
// - input clock divided by clock_divider_value plus one gives the tick.
// - tick clocks tone counter; divider period is the pwm period.
// - tone frequency is tick rate over two times tone value plus one.
// - pwm high amplitude clocks of divider plus one; full when amplitude exceeds.
// - amplitude_step is the linear step, unused for gong and exponential.
// - event when amplitude reaches limit upward in attack, downward in decay.
// - one duration lasts duration value plus one full tone cycles.
// - envelope enabled, each duration end steps amplitude once in direction.
// - envelope disabled, duration end reloads if config_ready, else stops.
// - all configuration registers readable and writable in any state.
// - any configuration register write clears config_ready.
// - reload copies amplitude to working buffer; envelope changes only buffer.
// - generator_enable low holds every counter at zero.
// - next_data_flag cleared by writing 1, writing 0 leaves it.
module stag_top (
   input wire logic mclk,
   input wire logic rst,
   input wire stag_pkg::stag_bus_req_type bus_req,
   output logic [stag_pkg::STAG_DATA_W-1:0] rdata,
   output logic tone_output,
   output logic amplitude_output,
   output logic limit_event,
   output logic next_data_flag
);
   import stag_pkg::*;

   logic [7:0] gen_ctrl_q;
   logic [7:0] env_ctrl_q;
   stag_config_type cfg_q;
   stag_config_type buf_q;
   logic [10:0] work_amp_q;
   logic [10:0] pcnt_q;
   logic [9:0] tcnt_q;
   logic [7:0] dcnt_q;
   logic tone_q;
   logic pwm_q;
   logic out_tone_q;
   logic limit_event_q;
   logic flag_q;
   logic [7:0] rdata_q;
   stag_state_type state_q;

   logic wr_en;
   logic active;
   logic tick;
   logic half_end;
   logic dur_end;
   logic start_load;
   logic end_reload;
   logic end_stop;
   logic end_step;
   logic cfg_write;
   logic [11:0] delta;
   logic [11:0] stepped;
   logic [10:0] next_amp;
   logic crossed;
   stag_shape_type shape;

   assign wr_en = bus_req.wr;
   // enable low or stop set both send the generator to idle and clear its counters
   assign active = gen_ctrl_q[STAG_GENERATOR_ENABLE_BIT] && !gen_ctrl_q[STAG_STOP_BIT];
   // gated by active so no step or event slips out in the cycle enable drops
   assign tick = active && (state_q == STAG_ST_RUN) && (pcnt_q == buf_q.divider);
   assign half_end = tick && (tcnt_q == buf_q.tone);
   // a falling tone edge closes one full tone cycle
   assign dur_end = half_end && tone_q && (dcnt_q == buf_q.duration_bits);
   assign start_load = active && (state_q == STAG_ST_IDLE)
                       && gen_ctrl_q[STAG_CONFIG_READY_BIT];
   assign end_step = dur_end && env_ctrl_q[STAG_ENVELOPE_ENABLE_BIT];
   assign end_reload = dur_end && !env_ctrl_q[STAG_ENVELOPE_ENABLE_BIT]
                       && gen_ctrl_q[STAG_CONFIG_READY_BIT];
   assign end_stop = dur_end && !env_ctrl_q[STAG_ENVELOPE_ENABLE_BIT]
                     && !gen_ctrl_q[STAG_CONFIG_READY_BIT];
   assign shape = stag_shape_type'(env_ctrl_q[STAG_SHAPE_LSB+1:STAG_SHAPE_LSB]);
   assign cfg_write = wr_en && (bus_req.addr >= STAG_ENVELOPE_CONTROL)
                      && (bus_req.addr <= STAG_TONE_CYCLES_PER_DURATION);

   // envelope step size per shape
   always_comb begin
      case (shape)
         STAG_SHAPE_LINEAR: delta = {1'b0, buf_q.step};
         // gong scales with amplitude, so a zero start never grows
         STAG_SHAPE_GONG: delta = {1'b0, work_amp_q >> STAG_GONG_SHIFT};
         STAG_SHAPE_EXP: delta = {1'b0, work_amp_q >> STAG_EXP_SHIFT} + 12'h001;
         default: delta = 12'h000;
      endcase
   end

   // saturating add or subtract on the working buffer
   always_comb begin
      if (!env_ctrl_q[STAG_ENVELOPE_DIRECTION_BIT]) begin
         stepped = {1'b0, work_amp_q} + delta;
         next_amp = stepped[11] ? STAG_AMP_MAX : stepped[10:0];
      end else begin
         stepped = {1'b0, work_amp_q} - delta;
         next_amp = stepped[11] ? STAG_VALUE_RESET : stepped[10:0];
      end
   end

   // crossing test: fire once when the limit is first reached
   always_comb begin
      if (!env_ctrl_q[STAG_ENVELOPE_DIRECTION_BIT]) begin
         crossed = (next_amp >= buf_q.limit) && (work_amp_q < buf_q.limit);
      end else begin
         crossed = (next_amp <= buf_q.limit) && (work_amp_q > buf_q.limit);
      end
   end

   // generator control and config_ready
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gen_ctrl_q <= STAG_CONTROL_RESET;
      end else if (wr_en && bus_req.addr == STAG_GENERATOR_CONTROL) begin
         gen_ctrl_q <= bus_req.wdata & 8'h87;
      end else if (cfg_write) begin
         gen_ctrl_q[STAG_CONFIG_READY_BIT] <= 1'b0;
      end
   end

   // configuration registers, writable in any state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         env_ctrl_q <= STAG_CONTROL_RESET;
         cfg_q <= '0;
      end else if (wr_en) begin
         case (bus_req.addr)
            STAG_ENVELOPE_CONTROL: env_ctrl_q <= bus_req.wdata & 8'h87;
            STAG_CLOCK_DIVIDER_HIGH: cfg_q.divider[10:8] <= bus_req.wdata[2:0];
            STAG_CLOCK_DIVIDER_LOW: cfg_q.divider[7:0] <= bus_req.wdata;
            STAG_TONE_HALF_PERIOD_HIGH: cfg_q.tone[9:8] <= bus_req.wdata[1:0];
            STAG_TONE_HALF_PERIOD_LOW: cfg_q.tone[7:0] <= bus_req.wdata;
            STAG_AMPLITUDE_DUTY_HIGH: cfg_q.amp[10:8] <= bus_req.wdata[2:0];
            STAG_AMPLITUDE_DUTY_LOW: cfg_q.amp[7:0] <= bus_req.wdata;
            STAG_AMPLITUDE_STEP_HIGH: cfg_q.step[10:8] <= bus_req.wdata[2:0];
            STAG_AMPLITUDE_STEP_LOW: cfg_q.step[7:0] <= bus_req.wdata;
            STAG_AMPLITUDE_LIMIT_HIGH: cfg_q.limit[10:8] <= bus_req.wdata[2:0];
            STAG_AMPLITUDE_LIMIT_LOW: cfg_q.limit[7:0] <= bus_req.wdata;
            STAG_TONE_CYCLES_PER_DURATION: cfg_q.duration_bits <= bus_req.wdata;
            default: cfg_q <= cfg_q;
         endcase
      end
   end

   // run state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= STAG_ST_IDLE;
      end else begin
         case (state_q)
            STAG_ST_IDLE: begin
               if (start_load) begin
                  state_q <= STAG_ST_RUN;
               end
            end
            STAG_ST_RUN: begin
               if (!active || end_stop) begin
                  state_q <= STAG_ST_IDLE;
               end
            end
            default: state_q <= STAG_ST_IDLE;
         endcase
      end
   end

   // working buffers; the programmed values stay untouched
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         buf_q <= '0;
         work_amp_q <= STAG_VALUE_RESET;
      end else if (start_load || end_reload) begin
         buf_q <= cfg_q;
         work_amp_q <= cfg_q.amp;
      end else if (end_step) begin
         work_amp_q <= next_amp;
      end
   end

   // prescaler counter, also the pwm phase
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pcnt_q <= STAG_VALUE_RESET;
      end else if (!active || state_q != STAG_ST_RUN || tick || end_reload) begin
         pcnt_q <= STAG_VALUE_RESET;
      end else begin
         pcnt_q <= pcnt_q + 11'h001;
      end
   end

   // tone counter and square tone, stepped by the tick
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tcnt_q <= 10'h000;
         tone_q <= 1'b0;
      end else if (!active || state_q != STAG_ST_RUN || end_reload) begin
         tcnt_q <= 10'h000;
         tone_q <= 1'b0;
      end else if (half_end) begin
         tcnt_q <= 10'h000;
         tone_q <= !tone_q;
      end else if (tick) begin
         tcnt_q <= tcnt_q + 10'h001;
      end
   end

   // duration counter, advanced on each falling tone edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dcnt_q <= 8'h00;
      end else if (!active || state_q != STAG_ST_RUN || dur_end) begin
         dcnt_q <= 8'h00;
      end else if (half_end && tone_q) begin
         dcnt_q <= dcnt_q + 8'h01;
      end
   end

   // pwm: high while phase is below amplitude, full when amplitude exceeds
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pwm_q <= 1'b0;
         out_tone_q <= 1'b0;
      end else begin
         pwm_q <= (state_q == STAG_ST_RUN) && active && (work_amp_q > pcnt_q);
         if (gen_ctrl_q[STAG_TONE_ONLY_BIT]) begin
            // disable silences even the bare tone at once
            out_tone_q <= tone_q && active;
         end else begin
            out_tone_q <= tone_q && (state_q == STAG_ST_RUN) && active
                          && (work_amp_q > pcnt_q);
         end
      end
   end

   // limit crossing pulse, one cycle after the step
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         limit_event_q <= 1'b0;
      end else begin
         limit_event_q <= end_step && crossed;
      end
   end

   // next data flag: a set in the same cycle as a clear wins
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (start_load || end_reload || end_stop) begin
         flag_q <= 1'b1;
      end else if (wr_en && bus_req.addr == STAG_NEXT_DATA_FLAG_REG
                   && bus_req.wdata[STAG_NEXT_DATA_FLAG_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   // read data, one cycle after the read strobe; unmapped reads zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_q <= 8'h00;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            STAG_GENERATOR_CONTROL: rdata_q <= gen_ctrl_q;
            STAG_ENVELOPE_CONTROL: rdata_q <= env_ctrl_q;
            STAG_CLOCK_DIVIDER_HIGH: rdata_q <= {5'h00, cfg_q.divider[10:8]};
            STAG_CLOCK_DIVIDER_LOW: rdata_q <= cfg_q.divider[7:0];
            STAG_TONE_HALF_PERIOD_HIGH: rdata_q <= {6'h00, cfg_q.tone[9:8]};
            STAG_TONE_HALF_PERIOD_LOW: rdata_q <= cfg_q.tone[7:0];
            STAG_AMPLITUDE_DUTY_HIGH: rdata_q <= {5'h00, cfg_q.amp[10:8]};
            STAG_AMPLITUDE_DUTY_LOW: rdata_q <= cfg_q.amp[7:0];
            STAG_AMPLITUDE_STEP_HIGH: rdata_q <= {5'h00, cfg_q.step[10:8]};
            STAG_AMPLITUDE_STEP_LOW: rdata_q <= cfg_q.step[7:0];
            STAG_AMPLITUDE_LIMIT_HIGH: rdata_q <= {5'h00, cfg_q.limit[10:8]};
            STAG_AMPLITUDE_LIMIT_LOW: rdata_q <= cfg_q.limit[7:0];
            STAG_TONE_CYCLES_PER_DURATION: rdata_q <= cfg_q.duration_bits;
            STAG_NEXT_DATA_FLAG_REG: rdata_q <= {7'h00, flag_q};
            STAG_WORKING_AMPLITUDE_HIGH: rdata_q <= {5'h00, work_amp_q[10:8]};
            STAG_WORKING_AMPLITUDE_LOW: rdata_q <= work_amp_q[7:0];
            STAG_DURATION_COUNT: rdata_q <= dcnt_q;
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign rdata = rdata_q;
   assign tone_output = out_tone_q;
   assign amplitude_output = pwm_q;
   assign limit_event = limit_event_q;
   assign next_data_flag = flag_q;
endmodule

// ==== tb/stag_asserts.sv ====
// concurrent checks on the ports of the sound tone amplitude generator
`timescale 1ns/100ps
module stag_asserts (
   input wire logic mclk,
   input wire logic rst,
   input wire stag_pkg::stag_bus_req_type bus_req,
   input wire logic [stag_pkg::STAG_DATA_W-1:0] rdata,
   input wire logic tone_output,
   input wire logic amplitude_output,
   input wire logic limit_event,
   input wire logic next_data_flag
);
   import stag_pkg::*;
   logic en_q;
   logic rdy_q;
   logic cfg_wr;
   logic keep_wr;
   // shadow of the control bits, rebuilt from bus traffic alone
   assign cfg_wr = bus_req.wr && bus_req.addr >= 5'h01 && bus_req.addr <= 5'h0c;
   assign keep_wr = bus_req.wr && bus_req.addr == STAG_NEXT_DATA_FLAG_REG && !bus_req.wdata[0];
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) en_q <= 1'b0;
      else if (bus_req.wr && bus_req.addr == STAG_GENERATOR_CONTROL) en_q <= bus_req.wdata[7];
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rdy_q <= 1'b0;
      else if (bus_req.wr && bus_req.addr == STAG_GENERATOR_CONTROL) rdy_q <= bus_req.wdata[1];
      else if (cfg_wr) rdy_q <= 1'b0;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   chk_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
      else $error("read data outside its answer cycle");
   chk_unmapped_zero: assert property (bus_req.rd && (bus_req.addr == 5'h0d
      || bus_req.addr == 5'h0f || bus_req.addr > 5'h12) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_ctrl_state: assert property (bus_req.rd && bus_req.addr == STAG_GENERATOR_CONTROL |=>
      rdata[7] == $past(en_q) && rdata[1] == $past(rdy_q) && rdata[6:3] == 4'h0)
      else $error("control readback wrong");
   chk_high_bytes: assert property (bus_req.rd && bus_req.addr inside {5'h02, 5'h06, 5'h08,
      5'h0a} |=> rdata[7:3] == 5'h00)
      else $error("high byte reserved bits set");
   chk_tone_byte: assert property (bus_req.rd && bus_req.addr == STAG_TONE_HALF_PERIOD_HIGH
      |=> rdata[7:2] == 6'h00)
      else $error("tone high byte reserved bits set");
   chk_flag_hold: assert property (keep_wr && next_data_flag && en_q |=> next_data_flag)
      else $error("writing zero cleared the flag");
   chk_event_pulse: assert property (limit_event |=> !limit_event)
      else $error("limit event longer than one cycle");
   chk_quiet_outputs: assert property (!en_q && !$past(en_q) |->
      !tone_output && !amplitude_output && !limit_event)
      else $error("output active while disabled");
   chk_dcnt_zero: assert property (bus_req.rd && bus_req.addr == STAG_DURATION_COUNT && !en_q
      && !$past(en_q) |=> rdata == 8'h00)
      else $error("duration count not held at zero");
endmodule

bind stag_top stag_asserts chk_i (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
   .tone_output(tone_output), .amplitude_output(amplitude_output),
   .limit_event(limit_event), .next_data_flag(next_data_flag));

// ==== tb/tb.sv ====
// self-checking bench of the sound tone amplitude generator
`timescale 1ns/100ps
module tb;
   import stag_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   stag_bus_req_type bus_req = '0;
   logic [7:0] rdata;
   logic tone_output, amplitude_output, limit_event, next_data_flag;
   int num_errors = 0, checked = 0, cyc = 0, hi_cnt = 0, ev_cnt = 0, tn_cnt = 0;
   int div_v = 3, tone_v = 1;
   int amp, a0, stp, lim, nxt, exp_ev, t0, h0, e0;
   logic [7:0] d;
   logic [10:0] w;
   logic [7:0] mask [2:12] = '{8'h07, 8'hff, 8'h03, 8'hff, 8'h07, 8'hff, 8'h07, 8'hff,
      8'h07, 8'hff, 8'hff};
   int amps [2] = '{2, 9};

   stag_top dut (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
      .tone_output(tone_output), .amplitude_output(amplitude_output),
      .limit_event(limit_event), .next_data_flag(next_data_flag));

   always #12.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      hi_cnt += amplitude_output;
      ev_cnt += limit_event;
      tn_cnt += tone_output;
      if (cyc > 20000) begin
         num_errors++;
         complete_run();
      end
   end

   task complete_run;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req.wr <= 1'b0;
   endtask
   task rd(input logic [4:0] a, output logic [7:0] v);
      @(posedge mclk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge mclk);
      bus_req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   task rw(input logic [4:0] a, output logic [10:0] v);
      rd(a, d);
      v = {d[2:0], 8'h00};
      rd(a + 5'h01, d);
      v[7:0] = d;
   endtask
   task ww(input logic [4:0] a, input int v);
      wr(a, {5'h00, v[10:8]});
      wr(a + 5'h01, v[7:0]);
   endtask
   // bounded wait for the tone to move into level lvl
   task edge_t(input logic lvl);
      int n;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         while (tone_output !== (p ? lvl : !lvl) && n < 3000) begin
            @(posedge mclk);
            #1 n++;
         end
         if (n >= 3000) chk("tone edge", 0, 1);
      end
   endtask
   // divider div_v, tone tone_v, one tone cycle per duration; short defaults save time
   task start(input int a, input int s, input int l, input logic [7:0] e);
      wr(STAG_GENERATOR_CONTROL, 8'h00);
      ww(STAG_CLOCK_DIVIDER_HIGH, div_v);
      ww(STAG_TONE_HALF_PERIOD_HIGH, tone_v);
      ww(STAG_AMPLITUDE_DUTY_HIGH, a);
      ww(STAG_AMPLITUDE_STEP_HIGH, s);
      ww(STAG_AMPLITUDE_LIMIT_HIGH, l);
      wr(STAG_TONE_CYCLES_PER_DURATION, 8'h00);
      wr(STAG_ENVELOPE_CONTROL, e);
      wr(STAG_GENERATOR_CONTROL, 8'h86);
   endtask

   initial begin
      void'($urandom(34326));
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      for (int a = 0; a < 20; a++) begin
         rd(a[4:0], d);
         chk("reset value", d, 0);
      end
      for (int a = 2; a < 13; a++) begin
         nxt = $urandom;
         wr(a[4:0], nxt[7:0]);
         rd(a[4:0], d);
         chk("readback", d, nxt[7:0] & mask[a]);
      end
      wr(5'h0f, 8'hff);
      rd(5'h0f, d);
      chk("unmapped", d, 0);
      wr(STAG_WORKING_AMPLITUDE_LOW, 8'hff);
      rd(STAG_WORKING_AMPLITUDE_LOW, d);
      chk("working amp read only", d, 0);
      wr(STAG_GENERATOR_CONTROL, 8'h02);
      wr(STAG_TONE_CYCLES_PER_DURATION, 8'h00);
      rd(STAG_GENERATOR_CONTROL, d);
      chk("config ready cleared", d, 0);
      foreach (amps[i]) begin
         start(amps[i], 1, 2047, 8'h00);
         edge_t(1);
         t0 = cyc;
         h0 = hi_cnt;
         edge_t(1);
         chk("tone period", cyc - t0, 16);
         chk("pwm high", hi_cnt - h0, 4 * (amps[i] < 4 ? amps[i] : 4));
         rw(STAG_WORKING_AMPLITUDE_HIGH, w);
         chk("amp held", w, amps[i]);
         chk("flag after reload", next_data_flag, 1);
         // mixed mode: tone gated by the pwm
         wr(STAG_GENERATOR_CONTROL, 8'h82);
         repeat (2) @(posedge mclk);
         #1 h0 = tn_cnt;
         repeat (16) @(posedge mclk);
         #1 chk("mixed tone", tn_cnt - h0, 2 * (amps[i] < 4 ? amps[i] : 4));
         wr(STAG_GENERATOR_CONTROL, 8'h86);
      end
      // config_ready low: duration end stops the generator
      // clear the flag right after a reload so only the stop can set it
      edge_t(0);
      wr(STAG_NEXT_DATA_FLAG_REG, 8'h01);
      #1 chk("flag before stop", next_data_flag, 0);
      wr(STAG_GENERATOR_CONTROL, 8'h84);
      repeat (40) @(posedge mclk);
      #1 chk("stopped tone", tone_output, 0);
      rd(STAG_DURATION_COUNT, d);
      chk("stopped count", d, 0);
      chk("flag at stop", next_data_flag, 1);
      wr(STAG_NEXT_DATA_FLAG_REG, 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk("flag kept", next_data_flag, 1);
      wr(STAG_NEXT_DATA_FLAG_REG, 8'h01);
      repeat (2) @(posedge mclk);
      #1 chk("flag cleared", next_data_flag, 0);
      for (int s = 0; s < 3; s++) begin
         for (int dr = 0; dr < 2; dr++) begin
            stp = $urandom_range(128, 1);
            // nonzero start amplitude keeps gong attack alive
            amp = dr ? $urandom_range(255, 1) : 2047 - $urandom_range(255, 0);
            lim = dr ? amp / 2 : amp + (2047 - amp) / 2;
            a0 = amp;
            exp_ev = 0;
            start(amp, stp, lim, {5'h10, s[1:0], dr[0]});
            e0 = ev_cnt;
            edge_t(1);
            rw(STAG_WORKING_AMPLITUDE_HIGH, w);
            chk("loaded amp", w, amp);
            repeat (5) begin
               edge_t(0);
               repeat (3) @(posedge mclk);
               nxt = (s == 0) ? stp : (s == 1) ? amp >> 1 : (amp >> 3) + 1;
               nxt = dr ? amp - nxt : amp + nxt;
               if (nxt < 0) nxt = 0;
               if (nxt > 2047) nxt = 2047;
               if (dr ? (amp > lim && nxt <= lim) : (amp < lim && nxt >= lim)) exp_ev++;
               amp = nxt;
               rw(STAG_WORKING_AMPLITUDE_HIGH, w);
               chk("envelope amp", w, amp);
            end
            chk("limit events", ev_cnt - e0, exp_ev);
            rw(STAG_AMPLITUDE_DUTY_HIGH, w);
            chk("programmed amp kept", w, a0);
         end
      end
      // legal divider and an audible tone
      div_v = 255;
      tone_v = 9;
      start(100, 1, 2047, 8'h00);
      edge_t(1);
      t0 = cyc;
      h0 = hi_cnt;
      edge_t(1);
      chk("slow tone period", cyc - t0, 2 * (tone_v + 1) * (div_v + 1));
      chk("slow pwm high", hi_cnt - h0, 2 * (tone_v + 1) * 100);
      wr(STAG_GENERATOR_CONTROL, 8'h00);
      repeat (3) @(posedge mclk);
      #1 chk("disabled outputs", {tone_output, amplitude_output}, 0);
      complete_run();
   end
endmodule
